// ### src/external_memory_port_pkg.sv
// Constants shared by the external memory port
package external_memory_port_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int HI_W = 8;
    // Control A field positions
    localparam int CA_ENABLE_BIT = 7;
    localparam int CA_SECTOR_LSB = 4;
    localparam int CA_WAIT_HI_LSB = 2;
    localparam int CA_WAIT_LO_LSB = 0;
    // Control B field positions
    localparam int CB_KEEPER_BIT = 7;
    localparam int CB_MASK_LSB = 0;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    // Wait select encodings
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_ONE = 2'h1;
    localparam logic [1:0] WAIT_TWO = 2'h2;
    localparam logic [1:0] WAIT_TWO_HOLD = 2'h3;
    // Sector limit: upper bits of address, 8 KB steps
    localparam int SECTOR_SHIFT = 13;
    localparam logic [2:0] SECTOR_NONE = 3'h0;
    // Mask value that keeps no high address bits
    localparam logic [2:0] MASK_ALL = 3'h7;
    localparam logic [3:0] HI_BITS_FULL = 4'h8;
    localparam logic [3:0] HI_BITS_BASE = 4'h8;
    // Default internal SRAM top (exclusive boundary)
    localparam logic [15:0] INT_TOP_DEFAULT = 16'h1100;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_STRB  = 3'b010,
        ST_WAIT  = 3'b011,
        ST_DONE  = 3'b100,
        ST_HOLD  = 3'b101
    } bus_state_t;
endpackage

// ### src/hi_addr_mask.sv
// High address pin release decoder
`timescale 1ns/1ns
module hi_addr_mask #(
    parameter int W = 8
) (
    input  wire logic [2:0]   mask,      // High mask field
    output logic      [W-1:0] keep       // One per pin driven by the port
);
    logic [3:0] nbits;
    always_comb begin
        if (mask == 3'h0) begin
            nbits = external_memory_port_pkg::HI_BITS_FULL;
        end else if (mask == external_memory_port_pkg::MASK_ALL) begin
            nbits = 4'h0;
        end else begin
            nbits = external_memory_port_pkg::HI_BITS_BASE - {1'b0, mask};
        end
    end
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_keep
            assign keep[i] = (4'(i) < nbits);
        end
    endgenerate
endmodule

// ### src/ext_mem_port.sv
// External memory port: muxed address/data, latch strobe, wait states
`timescale 1ns/1ns

module ext_mem_port #(
    parameter logic [15:0] INT_TOP = external_memory_port_pkg::INT_TOP_DEFAULT
) (
    input  wire logic        clk,            // System clock
    input  wire logic        arst_n,         // Async reset, active low
    input  wire logic [7:0]  ext_mem_control_a, // Enable, sector limit, waits
    input  wire logic [7:0]  ext_mem_control_b, // Keeper enable, high mask
    input  wire logic        req,            // CPU data access request pulse
    input  wire logic        req_write,      // Access is a write
    input  wire logic [15:0] req_addr,       // Access address
    input  wire logic [7:0]  req_wdata,      // Write data
    input  wire logic        next_ram,       // Next instruction accesses RAM
    output logic             busy,           // Access in progress
    output logic             done,           // Access complete pulse
    output logic             is_external,    // Current access targets external
    output logic             no_map,         // Disabled and above SRAM boundary
    output logic [7:0]       rdata,          // Read data captured
    input  wire logic [7:0]  port_a_out,     // Normal port output bits
    input  wire logic [7:0]  port_a_dir,     // Normal port direction bits
    input  wire logic [7:0]  port_c_out,     // Normal high port output bits
    input  wire logic [7:0]  port_c_dir,     // Normal high port direction bits
    input  wire logic [7:0]  ad_in,          // Muxed bus pin input
    output logic      [7:0]  ad_out,         // Muxed bus pin output
    output logic      [7:0]  ad_oe,          // Muxed bus pin enable
    output logic      [7:0]  ad_pullup,      // Muxed bus pull-up enable
    output logic      [7:0]  hi_out,         // High address pin output
    output logic      [7:0]  hi_oe,          // High address pin enable
    output logic             ale,            // Address latch strobe
    output logic             rd_n,           // Read strobe, active low
    output logic             wr_n            // Write strobe, active low
);
    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    logic       enable;
    logic [2:0] limit;
    logic [1:0] wait_hi;
    logic [1:0] wait_lo;
    logic       keeper_en;
    logic [7:0] keep_pins;
    assign enable    = ext_mem_control_a[external_memory_port_pkg::CA_ENABLE_BIT];
    assign limit     = ext_mem_control_a[external_memory_port_pkg::CA_SECTOR_LSB +: 3];
    assign wait_hi   = ext_mem_control_a[external_memory_port_pkg::CA_WAIT_HI_LSB +: 2];
    assign wait_lo   = ext_mem_control_a[external_memory_port_pkg::CA_WAIT_LO_LSB +: 2];
    assign keeper_en = ext_mem_control_b[external_memory_port_pkg::CB_KEEPER_BIT];

    hi_addr_mask #(
        .W(external_memory_port_pkg::HI_W)
    ) u_mask (
        .mask(ext_mem_control_b[external_memory_port_pkg::CB_MASK_LSB +: 3]),
        .keep(keep_pins)
    );

    // ----------------------------------------
    // Access classification
    // ----------------------------------------
    logic       req_ext;
    logic       upper;
    logic [1:0] wait_sel;
    assign req_ext = req_addr >= INT_TOP;
    // Zero limit treats all space as upper sector
    assign upper = (limit == external_memory_port_pkg::SECTOR_NONE) ||
                   (req_addr[15:external_memory_port_pkg::SECTOR_SHIFT] >= limit);
    assign wait_sel = upper ? wait_hi : wait_lo;

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    external_memory_port_pkg::bus_state_t st_r;
    logic [1:0]  wait_r;
    logic [1:0]  wcnt_r;
    logic        ext_r;
    logic        wr_r;
    logic        nram_r;
    logic [15:0] addr_r;
    logic [7:0]  wdata_r;
    logic [1:0]  wait_len;
    assign wait_len = (wait_r == external_memory_port_pkg::WAIT_NONE) ? 2'h0 :
                      (wait_r == external_memory_port_pkg::WAIT_ONE)  ? 2'h1 : 2'h2;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r   <= external_memory_port_pkg::ST_IDLE;
            wcnt_r <= 2'h0;
        end else begin
            case (st_r)
                external_memory_port_pkg::ST_IDLE: begin
                    if (req && enable) begin
                        st_r <= external_memory_port_pkg::ST_ADDR;
                    end
                end
                external_memory_port_pkg::ST_ADDR: begin
                    st_r   <= external_memory_port_pkg::ST_STRB;
                    wcnt_r <= 2'h0;
                end
                external_memory_port_pkg::ST_STRB: begin
                    st_r <= (wait_len == 2'h0) ? external_memory_port_pkg::ST_DONE : external_memory_port_pkg::ST_WAIT;
                end
                external_memory_port_pkg::ST_WAIT: begin
                    wcnt_r <= wcnt_r + 2'h1;
                    if (wcnt_r + 2'h1 == wait_len) begin
                        st_r <= (wait_r == external_memory_port_pkg::WAIT_TWO_HOLD) ? external_memory_port_pkg::ST_HOLD
                                                                    : external_memory_port_pkg::ST_DONE;
                    end
                end
                external_memory_port_pkg::ST_HOLD: st_r <= external_memory_port_pkg::ST_DONE;
                external_memory_port_pkg::ST_DONE: st_r <= external_memory_port_pkg::ST_IDLE;
                default: st_r <= external_memory_port_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_r  <= external_memory_port_pkg::WAIT_NONE;
            ext_r   <= 1'b0;
            wr_r    <= 1'b0;
            nram_r  <= 1'b0;
            addr_r  <= 16'h0000;
            wdata_r <= 8'h00;
        end else if (st_r == external_memory_port_pkg::ST_IDLE && req && enable) begin
            wait_r  <= wait_sel;
            ext_r   <= req_ext;
            wr_r    <= req_write;
            addr_r  <= req_addr;
            wdata_r <= req_wdata;
        end else if (st_r != external_memory_port_pkg::ST_DONE) begin
            // Sampled every cycle except the accepting cycle and DONE, so no stale value from the last access
            nram_r <= next_ram;
        end
    end

    // Read data taken at the last strobe edge, while the memory still drives
    logic strb_last;
    assign strb_last = ((st_r == external_memory_port_pkg::ST_STRB) && (wait_len == 2'h0)) ||
                       ((st_r == external_memory_port_pkg::ST_WAIT) && (wcnt_r + 2'h1 == wait_len));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (ext_r && !wr_r && strb_last) begin
            rdata <= ad_in;
        end
    end

    // Last bus level: ad_out while any pin is driven, else sampled from ad_in
    logic [7:0] last_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_r <= 8'h00;
        end else if (|ad_oe) begin
            last_r <= ad_out;
        end else begin
            last_r <= ad_in;
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    logic in_addr;
    logic in_data;
    logic strobe;
    assign in_addr = (st_r == external_memory_port_pkg::ST_ADDR);
    assign in_data = (st_r == external_memory_port_pkg::ST_STRB) || (st_r == external_memory_port_pkg::ST_WAIT);
    assign strobe  = in_data && ext_r;
    assign busy    = (st_r != external_memory_port_pkg::ST_IDLE);
    assign done    = (st_r == external_memory_port_pkg::ST_DONE);
    assign is_external = ext_r;
    assign no_map  = !enable && (req_addr >= INT_TOP);

    always_comb begin
        ad_out = port_a_out;
        ad_oe  = port_a_dir;
        ale    = 1'b0;
        if (enable) begin
            ad_oe  = 8'h00;
            ad_out = 8'h00;
            if (in_addr) begin
                ad_out = addr_r[7:0];
                ad_oe  = 8'hff;
                ale    = 1'b1;
            end else if (in_data && wr_r) begin
                ad_out = wdata_r;
                ad_oe  = 8'hff;
            end else if (st_r == external_memory_port_pkg::ST_DONE && nram_r) begin
                // Trailing strobe lands in DONE, one period after the last STRB, WAIT or HOLD cycle
                ale = 1'b1;
            end
            // ALE stays low across STRB/WAIT
        end
        // Keeper yields while the memory drives a read
        if (keeper_en && ad_oe == 8'h00 && !(strobe && !wr_r)) begin
            ad_out = last_r;
            ad_oe  = 8'hff;
        end
    end

    assign ad_pullup = (enable ? 8'h00 : ~port_a_dir) & port_a_out | (enable ? port_a_out : 8'h00);

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (enable && keep_pins[i]) begin
                hi_out[i] = addr_r[8 + i];
                hi_oe[i]  = 1'b1;
            end else begin
                hi_out[i] = port_c_out[i];
                hi_oe[i]  = port_c_dir[i];
            end
        end
    end

    assign rd_n = !(strobe && !wr_r);
    assign wr_n = !(strobe && wr_r);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_addr_phase;
        ale && (st_r == external_memory_port_pkg::ST_ADDR);
    endsequence
    latch_low_data_a: assert property (@(posedge clk) disable iff (!arst_n)
        in_data |-> !ale) else $error("latch strobe high in data phase");
    addr_at_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_addr_phase |-> ad_oe == 8'hff && ad_out == addr_r[7:0]) else $error("address not valid");
    internal_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
        !ext_r |-> rd_n && wr_n) else $error("strobe on internal access");
    zero_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_addr_phase and (wait_r == external_memory_port_pkg::WAIT_NONE) |=> ##1 done) else $error("zero wait length");
    one_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_addr_phase and (wait_r == external_memory_port_pkg::WAIT_ONE) |=> ##2 done) else $error("one wait length");
    two_wait_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_addr_phase and (wait_r == external_memory_port_pkg::WAIT_TWO_HOLD) |=> ##4 done) else $error("hold wait length");
    two_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_addr_phase and (wait_r == external_memory_port_pkg::WAIT_TWO) |=> ##3 done) else $error("two wait length");
    keeper_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
        keeper_en && enable && !busy |-> ad_oe == 8'hff && ad_out == last_r) else $error("bus keeper not holding");
    read_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        !rd_n |-> ad_oe == 8'h00) else $error("bus driven during read strobe");
    hi_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
        enable |-> (hi_oe & keep_pins) == keep_pins && (hi_out & keep_pins) == (addr_r[15:8] & keep_pins))
        else $error("high address pins not driven");
    trail_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        done && enable && !nram_r |-> !ale) else $error("trailing strobe without RAM");
    disabled_pins_a: assert property (@(posedge clk) disable iff (!arst_n)
        !enable && !keeper_en |-> ad_oe == port_a_dir && !ale) else $error("pins not released");
    write_strobe_a: assert property (@(posedge clk) disable iff (!arst_n)
        !wr_n |-> ad_oe == 8'hff && ad_out == wdata_r) else $error("write data missing");
endmodule

// ### verif/sram_model.sv
// Behavioural external SRAM behind an octal address latch
`timescale 1ns/1ns
module sram_model (
    input  wire logic       clk,    // System clock
    input  wire logic [7:0] ad_out, // Port bus drive
    input  wire logic [7:0] ad_oe,  // Port bus enable
    input  wire logic [7:0] hi_out, // High address pins
    input  wire logic       ale,    // Latch strobe
    input  wire logic       rd_n,   // Read strobe
    input  wire logic       wr_n,   // Write strobe
    output logic      [7:0] ad_in   // Resolved bus level
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat_r;
    logic [7:0] last_r = 8'h00;
    logic       rd_q_r = 1'b0;
    logic [7:0] drv;
    initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
    // Clocked by the system clock, with latch and write gated by the port's strobes
    always @(posedge clk) begin
        if (ale) lat_r <= ad_out;
        if (!wr_n) mem[{hi_out, lat_r}] <= ad_in;
        rd_q_r <= !rd_n;
        last_r <= ad_in;
    end
    // Data held one cycle past the strobe; otherwise the bus floats to the inverse
    assign drv = (!rd_n || rd_q_r) ? mem[{hi_out, lat_r}] : ~last_r;
    assign ad_in = (ad_oe & ad_out) | (~ad_oe & drv);
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the external memory port
`timescale 1ns/1ns
module tb_top;
    logic clk = 0, arst_n = 0, req = 0, req_write = 0, next_ram = 0;
    logic [7:0] ctrl_a = 0, ctrl_b = 0, req_wdata = 0, port_a_out = 0, port_a_dir = 0;
    logic [7:0] port_c_out = 0, port_c_dir = 0, ad_in, ad_out, ad_oe, ad_pullup, hi_out, hi_oe, rdata;
    logic [15:0] req_addr = 0;
    logic busy, done, is_external, no_map, ale, rd_n, wr_n;
    logic [7:0] shadow [logic [15:0]];
    int n_fail = 0, compares = 0, seed_v;
    logic [15:0] ra;
    always #50 clk = ~clk;
    ext_mem_port dut (.clk(clk), .arst_n(arst_n), .ext_mem_control_a(ctrl_a), .ext_mem_control_b(ctrl_b),
        .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .next_ram(next_ram),
        .busy(busy), .done(done), .is_external(is_external), .no_map(no_map), .rdata(rdata),
        .port_a_out(port_a_out), .port_a_dir(port_a_dir), .port_c_out(port_c_out), .port_c_dir(port_c_dir),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .ad_pullup(ad_pullup), .hi_out(hi_out),
        .hi_oe(hi_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
    sram_model u_mem (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe), .hi_out(hi_out), .ale(ale),
        .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [1:0] exp_wait(logic [7:0] ca, logic [15:0] a);
        if (ca[6:4] == 3'h0 || a[15:13] >= ca[6:4]) return ca[3:2];
        return ca[1:0];
    endfunction
    // One CPU access; walks the cycles and counts strobe activity
    task automatic access(logic [7:0] ca, logic wr, logic [15:0] a, logic [7:0] d, logic nr);
        int n, lo, bad;
        logic [1:0] w;
        logic ext;
        logic [7:0] keep, ev;
        w = exp_wait(ca, a);
        ext = a >= external_memory_port_pkg::INT_TOP_DEFAULT;
        keep = (ctrl_b[2:0] == 3'h7) ? 8'h00 : 8'hff >> ctrl_b[2:0];
        ev = shadow.exists(a) ? shadow[a] : a[7:0] ^ a[15:8];
        ctrl_a = ca; req = 1; req_write = wr; req_addr = a; req_wdata = d; next_ram = nr; port_c_out = a[15:8];
        @(posedge clk); #1;
        req = 0; n = 1; lo = 0; bad = 0;
        check("ale addr", ale, 1'b1);
        check("ad_out addr", ad_out, a[7:0]);
        check("ad_oe addr", ad_oe, 8'hff);
        check("hi_oe", hi_oe, keep);
        check("hi_out", hi_out & keep, a[15:8] & keep);
        while (done !== 1'b1 && n < 10) begin
            @(posedge clk); #1;
            n++;
            if (done !== 1'b1) begin
                if ((wr ? wr_n : rd_n) === 1'b0) lo++;
                if ((wr ? rd_n : wr_n) !== 1'b1 || ale !== 1'b0) bad++;
                if (wr && wr_n === 1'b0 && ad_out !== d) bad++;
            end
        end
        check("strobe misuse", 16'(bad), 16'h0);
        check("strobe cycles", 16'(lo), ext ? 16'(w == 0 ? 1 : (w == 1 ? 2 : 3)) : 16'h0);
        check("is_external", is_external, ext);
        if (ext) begin
            check("latency", 16'(n), 16'(3 + w));
            check("trailing ale", ale, nr);
        end
        @(posedge clk); #1;
        if (ext && !wr) check("rdata", rdata, ev);
        if (ext && wr) shadow[a] = d;
    endtask
    initial begin
        #(50000 * 100);
        n_fail++;
        complete_run;
    end
    initial begin
        seed_v = $urandom(5299);
        repeat (10) @(posedge clk);
        #1 arst_n = 1;
        port_a_out = 8'h5a; port_a_dir = 8'hc3; req_addr = 16'h1100;
        #1 check("no_map top", no_map, 1'b1);
        req_addr = 16'h10ff;
        #1 check("no_map below", no_map, 1'b0);
        check("ad_oe off", ad_oe, 8'hc3);
        check("ad_out off", ad_out, 8'h5a);
        check("pullup", ad_pullup, 8'h5a & ~8'hc3);
        @(posedge clk); #1 req = 1;
        @(posedge clk); #1 req = 0;
        check("refused", busy, 1'b0);
        // Every wait code in both sectors, right at the 0x8000 boundary
        for (int k = 0; k < 8; k++) access({1'b1, 3'h4, k[1:0], ~k[1:0]}, k[0], k[2] ? 16'h8000 : 16'h7fff, 8'(k), k[1]);
        access({1'b1, 3'h0, 2'h2, 2'h0}, 1'b0, 16'h1200, 8'h00, 1'b1);
        access(8'h83, 1'b1, 16'h0400, 8'ha5, 1'b0);
        for (int m = 0; m < 8; m++) begin
            ctrl_b = 8'(m);
            access(8'h80, 1'b0, 16'hc1f0 + 16'(m), 8'h00, 1'b0);
        end
        ctrl_b = 8'h80;
        access(8'h80, 1'b0, 16'h2345, 8'h00, 1'b0);
        check("keeper idle", ad_oe, 8'hff);
        ctrl_b = 8'h00; port_a_dir = 8'h00;
        repeat (150) begin
            ra = 16'($urandom);
            access({1'b1, 3'($urandom), 4'($urandom)}, 1'b1, ra, 8'($urandom), 1'($urandom));
            access({1'b1, 3'($urandom), 4'($urandom)}, 1'b0, ra, 8'h00, 1'($urandom));
        end
        complete_run;
    end
endmodule
